// ===== core/txcr_frame.sv
`default_nettype none
module txcr_frame
  import txcr_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic isoa_in,
  input wire logic anctl_in,
  input wire logic card_idle_in,
  input wire logic wupa_in,
  input wire logic [2:0] split_bits_in,
  output logic bit_oriented_out,
  output logic no_parity_out,
  output logic par_err_out
);
  logic split;
  assign split = split_bits_in != TXCR_NO_SPLIT;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bit_oriented_out <= 1'b0;
      no_parity_out <= 1'b0;
    end else begin
      bit_oriented_out <= isoa_in && split;
      no_parity_out <= isoa_in && split;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      par_err_out <= 1'b0;
    end else begin
      par_err_out <= wupa_in && anctl_in && card_idle_in && split;
    end
  end
endmodule : txcr_frame
`default_nettype wire

// ===== core/txcr_pkg.sv
`default_nettype none
package txcr_pkg;
  localparam logic [31:0] TXCR_ADDR_CNT_HI = 32'h0000001D * 32'h4;
  localparam logic [31:0] TXCR_ADDR_CNT_LO = 32'h0000001E * 32'h4;
  localparam logic [31:0] TXCR_ADDR_RATE = 32'h0000001F * 32'h4;
  localparam logic [31:0] TXCR_ADDR_ADC = 32'h00000020 * 32'h4;
  localparam logic [31:0] TXCR_ADDR_CTRL = 32'h00000100;
  localparam logic [31:0] TXCR_ADDR_STAT = 32'h00000104;
  localparam logic [7:0] TXCR_RESET_BYTE = 8'h00;
  localparam logic [2:0] TXCR_NO_SPLIT = 3'h0;
  localparam int TXCR_LO_SHIFT = 3;
  localparam int TXCR_RATE_SHIFT = 4;
  localparam logic [1:0] TXCR_HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] TXCR_HSIZE_WORD = 3'h2;
  localparam int TXCR_CTRL_ANCTL = 0;
  localparam int TXCR_CTRL_ISOA = 1;
  localparam int TXCR_STAT_BITOR = 0;
  localparam int TXCR_STAT_NOPAR = 1;
endpackage : txcr_pkg
`default_nettype wire

// ===== core/txcr_regs.sv
`default_nettype none
module txcr_regs
  import txcr_pkg::*;
(
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic SET_DEFAULT_IN,
  input wire logic CARD_IDLE_IN,
  input wire logic WUPA_IN,
  input wire logic RATE_VALID_IN,
  input wire logic [3:0] RATE_IN,
  input wire logic ADC_DONE_IN,
  input wire logic [7:0] ADC_IN,
  output logic [12:0] TX_BYTES_OUT,
  output logic [2:0] SPLIT_BITS_OUT,
  output logic BIT_ORIENTED_OUT,
  output logic NO_PARITY_OUT,
  output logic PAR_ERR_OUT
);
  logic [7:0] cnt_hi;
  logic [7:0] cnt_lo;
  logic [3:0] rate;
  logic [7:0] adc;
  logic [1:0] ctrl;
  logic wr_pend;
  logic [31:0] wr_addr;
  logic take;
  logic clr;
  logic bit_oriented;
  logic no_parity;
  logic par_err;
  logic [31:0] next_rdata;

  assign take = HSEL_IN && HREADY_IN && HTRANS_IN == TXCR_HTRANS_NONSEQ;
  assign clr = RST_IN || SET_DEFAULT_IN;

  // zero-wait slave: writes land one cycle after the address phase
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      wr_pend <= 1'b0;
      wr_addr <= 32'h00000000;
    end else begin
      wr_pend <= take && HWRITE_IN && HSIZE_IN == TXCR_HSIZE_WORD;
      wr_addr <= HADDR_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clr) begin
      cnt_hi <= TXCR_RESET_BYTE;
      cnt_lo <= TXCR_RESET_BYTE;
    end else if (wr_pend && wr_addr == TXCR_ADDR_CNT_HI) begin
      cnt_hi <= HWDATA_IN[7:0];
    end else if (wr_pend && wr_addr == TXCR_ADDR_CNT_LO) begin
      cnt_lo <= HWDATA_IN[7:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clr) begin
      ctrl <= 2'h0;
    end else if (wr_pend && wr_addr == TXCR_ADDR_CTRL) begin
      ctrl <= HWDATA_IN[1:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clr) begin
      rate <= 4'h0;
    end else if (RATE_VALID_IN) begin
      rate <= RATE_IN;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clr) begin
      adc <= TXCR_RESET_BYTE;
    end else if (ADC_DONE_IN) begin
      adc <= ADC_IN;
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    case (HADDR_IN)
      TXCR_ADDR_CNT_HI: next_rdata = {24'h000000, cnt_hi};
      TXCR_ADDR_CNT_LO: next_rdata = {24'h000000, cnt_lo};
      TXCR_ADDR_RATE: next_rdata = {24'h000000, rate, 4'h0};
      TXCR_ADDR_ADC: next_rdata = {24'h000000, adc};
      TXCR_ADDR_CTRL: next_rdata = {30'h00000000, ctrl};
      TXCR_ADDR_STAT: next_rdata = {30'h00000000, no_parity, bit_oriented};
      default: next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      HRDATA_OUT <= 32'h00000000;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
      if (take && !HWRITE_IN) begin
        HRDATA_OUT <= next_rdata;
      end
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (clr) begin
      TX_BYTES_OUT <= 13'h0000;
      SPLIT_BITS_OUT <= TXCR_NO_SPLIT;
      BIT_ORIENTED_OUT <= 1'b0;
      NO_PARITY_OUT <= 1'b0;
      PAR_ERR_OUT <= 1'b0;
    end else begin
      TX_BYTES_OUT <= {cnt_hi, cnt_lo[7:TXCR_LO_SHIFT]};
      SPLIT_BITS_OUT <= cnt_lo[2:0];
      BIT_ORIENTED_OUT <= bit_oriented;
      NO_PARITY_OUT <= no_parity;
      PAR_ERR_OUT <= par_err;
    end
  end

  txcr_frame u_frame (
    .clk_in(CLK_IN),
    .rst_in(clr),
    .isoa_in(ctrl[TXCR_CTRL_ISOA]),
    .anctl_in(ctrl[TXCR_CTRL_ANCTL]),
    .card_idle_in(CARD_IDLE_IN),
    .wupa_in(WUPA_IN),
    .split_bits_in(cnt_lo[2:0]),
    .bit_oriented_out(bit_oriented),
    .no_parity_out(no_parity),
    .par_err_out(par_err)
  );
endmodule : txcr_regs
`default_nettype wire

// ===== test/tb.sv
`default_nettype none
`define CK(n, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; $display("MISMATCH %s %0h %0h", n, e, a); end end
module tb;
  import txcr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK_IN = 0, RST_IN = 1, HSEL_IN = 1, HWRITE_IN = 0, HREADY_IN, HREADYOUT_OUT, HRESP_OUT, rdp = 0;
  logic SET_DEFAULT_IN = 0, CARD_IDLE_IN = 0, WUPA_IN = 0, RATE_VALID_IN = 0, ADC_DONE_IN = 0;
  logic BIT_ORIENTED_OUT, NO_PARITY_OUT, PAR_ERR_OUT;
  logic [31:0] HADDR_IN = 0, HWDATA_IN = 0, HRDATA_OUT, r = 84991, d, ev;
  logic [1:0] HTRANS_IN = 0;
  logic [2:0] HSIZE_IN = 2, SPLIT_BITS_OUT;
  logic [3:0] RATE_IN = 0;
  logic [7:0] ADC_IN = 0;
  logic [12:0] TX_BYTES_OUT;
  logic [31:0] q[$];
  int failures = 0, n_compared = 0, npar = 0, cyc = 0;
  assign HREADY_IN = HREADYOUT_OUT;
  txcr_regs uut (.*);
  initial forever #2 CLK_IN = ~CLK_IN;
  function automatic logic [31:0] lf(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lf
  // one single transfer; for reads d is the expected word
  task automatic x(input logic w, input logic [2:0] s, input logic [31:0] a, input logic [31:0] d);
    HTRANS_IN <= 2'h2; HADDR_IN <= a; HWRITE_IN <= w; HSIZE_IN <= s;
    do @(posedge CLK_IN); while (HREADY_IN !== 1'b1);
    HTRANS_IN <= 2'h0; HWDATA_IN <= d; rdp <= !w;
    if (!w) q.push_back(d);
    do @(posedge CLK_IN); while (HREADY_IN !== 1'b1);
    rdp <= 1'b0;
  endtask : x
  task wrap_up;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  always @(posedge CLK_IN) begin
    cyc++;
    if (PAR_ERR_OUT === 1'b1) npar++;
    if (rdp) begin
      ev = q.pop_front();
      `CK("rdata", ev, HRDATA_OUT)
    end
    if (cyc > 3000) begin failures++; wrap_up(); end
  end
  task automatic pulse(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask : pulse
  initial begin
    pulse(2); RST_IN <= 0; pulse(1);
    for (int i = 0; i < 5; i++) x(0, 2, 32'h74 + 4 * i, 0);
    for (int i = 0; i < 4; i++) begin
      r = lf(r); d = i ? r : 32'hFFFF; // first pass is the 8191 ceiling
      x(1, 2, TXCR_ADDR_CNT_HI, d[15:8]); x(1, 2, TXCR_ADDR_CNT_LO, d[7:0]);
      x(0, 2, TXCR_ADDR_CNT_HI, d[15:8]); x(0, 2, TXCR_ADDR_CNT_LO, d[7:0]);
      `CK("tx", {d[15:8], d[7:3]}, TX_BYTES_OUT)
      `CK("split", d[2:0], SPLIT_BITS_OUT)
      `CK("bitoff", 1'b0, BIT_ORIENTED_OUT)
    end
    x(1, 0, TXCR_ADDR_CNT_HI, 32'h5A); x(0, 2, TXCR_ADDR_CNT_HI, d[15:8]);
    x(1, 2, TXCR_ADDR_RATE, 32'hFF); x(0, 2, TXCR_ADDR_RATE, 0);
    RATE_IN <= r[3:0]; ADC_IN <= r[11:4]; RATE_VALID_IN <= 1; ADC_DONE_IN <= 1; pulse(1);
    RATE_VALID_IN <= 0; ADC_DONE_IN <= 0; pulse(1);
    x(0, 2, TXCR_ADDR_RATE, {r[3:0], 4'h0}); x(0, 2, TXCR_ADDR_ADC, r[11:4]);
    x(1, 2, TXCR_ADDR_CTRL, 3); x(1, 2, TXCR_ADDR_CNT_LO, 5); pulse(3);
    `CK("bitmode", 1'b1, BIT_ORIENTED_OUT)
    `CK("nopar", 1'b1, NO_PARITY_OUT)
    x(0, 2, TXCR_ADDR_STAT, 3);
    CARD_IDLE_IN <= 1; WUPA_IN <= 1; pulse(1); WUPA_IN <= 0; pulse(4);
    `CK("parevt", 1, npar)
    SET_DEFAULT_IN <= 1; pulse(1); SET_DEFAULT_IN <= 0; pulse(2);
    `CK("txclr", 13'h0, TX_BYTES_OUT)
    WUPA_IN <= 1; pulse(1); WUPA_IN <= 0; pulse(4);
    `CK("parnone", 1, npar)
    for (int i = 0; i < 4; i++) x(0, 2, 32'h74 + 4 * i, 0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire

// ===== test/txcr_sva.sv
`default_nettype none
module txcr_sva (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SET_DEFAULT_IN,
  input wire logic CARD_IDLE_IN,
  input wire logic WUPA_IN,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic [12:0] TX_BYTES_OUT,
  input wire logic [2:0] SPLIT_BITS_OUT,
  input wire logic BIT_ORIENTED_OUT,
  input wire logic NO_PARITY_OUT,
  input wire logic PAR_ERR_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus not ready");
  a_frame_pair: assert property (BIT_ORIENTED_OUT == NO_PARITY_OUT)
    else $error("frame flags differ");
  a_split_none: assert property ($past(SPLIT_BITS_OUT) == 3'h0 |-> !BIT_ORIENTED_OUT)
    else $error("bit mode without split");
  a_parerr_cause: assert property (PAR_ERR_OUT |-> $past(WUPA_IN, 2))
    else $error("parity event uncaused");
  a_parerr_pulse: assert property (PAR_ERR_OUT |=> !PAR_ERR_OUT)
    else $error("parity event too long");
  a_parerr_quiet: assert property (WUPA_IN && (!CARD_IDLE_IN || SPLIT_BITS_OUT == 3'h0) |-> ##2 !PAR_ERR_OUT)
    else $error("parity event unexpected");
  a_default_clear: assert property (SET_DEFAULT_IN |=> ##1 TX_BYTES_OUT == 13'h0 && SPLIT_BITS_OUT == 3'h0)
    else $error("counts not cleared");
  a_reset_clear: assert property ($fell(RST_IN) |-> TX_BYTES_OUT == 13'h0 && !PAR_ERR_OUT)
    else $error("reset values wrong");
endmodule : txcr_sva
bind txcr_regs txcr_sva u_sva (.*);
`default_nettype wire
